/* File: hw/aqc_pkg.sv */
package aqc_pkg;
  // ==========================================================
  // Register map
  localparam logic [31:0] ADC_CLOCK_MUX_CONTROL_ADDR = 32'h00ca000a;
  localparam logic [31:0] QUEUE_ONE_CONTROL_ADDR     = 32'h00ca000c;
  localparam logic [15:0] ADC_CLOCK_MUX_CONTROL_RST  = 16'h0000;
  localparam logic [15:0] QUEUE_ONE_CONTROL_RST      = 16'h0000;
  // ==========================================================
  // Field positions
  localparam int MUX_MODE_BIT     = 15;
  localparam int TRIG_SWAP_BIT    = 14;
  localparam int DIV_LSB          = 0;
  localparam int DIV_WIDTH        = 7;
  localparam int Q1_CIE_BIT       = 15;
  localparam int Q1_PIE_BIT       = 14;
  localparam int Q1_SSE_BIT       = 13;
  localparam int Q1_MODE_LSB      = 8;
  localparam int Q1_MODE_WIDTH    = 5;
  // ==========================================================
  // Divider constants
  localparam logic [6:0] DIV_ZERO_READ   = 7'h01;
  localparam logic [6:0] DIV_ZERO_EFFECT = 7'h01;
  // Channel limits
  localparam logic [4:0] CHAN_MAX_EXT = 5'h12;
  localparam logic [4:0] CHAN_MAX_INT = 5'h08;
  // ==========================================================
  // Queue 1 modes
  localparam logic [4:0] Q1_MODE_DISABLED = 5'h00;
  localparam logic [4:0] Q1_MODE_SW_SINGLE = 5'h01;
  localparam logic [4:0] Q1_MODE_RISE_SINGLE = 5'h02;
  localparam logic [4:0] Q1_MODE_FALL_SINGLE = 5'h03;
  localparam logic [4:0] Q1_MODE_TIMER_FIRST = 5'h04;
  localparam logic [4:0] Q1_MODE_TIMER_LAST = 5'h0e;
  localparam logic [4:0] Q1_MODE_GATED_SINGLE = 5'h0f;
endpackage

/* File: hw/aqc_div_if.sv */
`timescale 1ns/1ps
interface aqc_div_if;
  logic [6:0] divider_field;
  logic       sample_tick;
  modport ctrl (output divider_field, input sample_tick);
  modport div (input divider_field, output sample_tick);
endinterface

/* File: hw/aqc_prescaler.sv */
`timescale 1ns/1ps
module aqc_prescaler (
  input  wire logic core_clk_i,
  input  wire logic reset_n_i,
  aqc_div_if.div    div_bus
);
  logic [6:0] count_q;
  logic [6:0] count_d;
  logic [6:0] terminal;
  logic       wrap;
  logic       tick_q;

  // ==========================================================
  // Zero behaves as one: divide by two
  assign terminal = (div_bus.divider_field == 7'h00) ? aqc_pkg::DIV_ZERO_EFFECT
                                                     : div_bus.divider_field;
  assign wrap    = (count_q >= terminal);
  assign count_d = wrap ? 7'h00 : 7'(count_q + 7'h01);
  assign div_bus.sample_tick = tick_q;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_q <= 7'h00;
      tick_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      tick_q  <= wrap;
    end
  end

  property p_tick_spacing;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      ($rose(tick_q) && $stable(div_bus.divider_field)) |=> !tick_q;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("Sample tick wider than one cycle");
endmodule // aqc_prescaler

/* File: hw/aqc_ctrl.sv */
`timescale 1ns/1ps
module aqc_ctrl (
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [31:0] bus_addr_i,
  input  wire logic        bus_sel_i,
  input  wire logic        bus_wr_i,
  input  wire logic [1:0]  bus_byte_en_i,
  input  wire logic [15:0] bus_wdata_i,
  output logic      [15:0] bus_rdata_o,
  output logic             bus_ack_o,
  output logic             bus_err_o,
  input  wire logic        stop_mode_i,
  input  wire logic        test_mode_i,
  input  wire logic [2:1]  ext_trigger_pins_i,
  input  wire logic [1:0]  mux_addr_i,
  input  wire logic        q1_scan_done_i,
  input  wire logic        q1_last_ccw_done_i,
  input  wire logic        q1_pause_ccw_done_i,
  output logic             sample_clock_o,
  output logic             external_mux_mode_o,
  output logic [4:0]       channel_limit_o,
  output logic [1:0]       mux_address_pins_o,
  output logic [1:0]       mux_address_oe_o,
  output logic             q1_trigger_o,
  output logic             q2_trigger_o,
  output logic [4:0]       q1_mode_field_o,
  output logic             q1_single_scan_arm_o,
  output logic             q1_complete_irq_o,
  output logic             q1_pause_irq_o
);
  // ==========================================================
  // Register state
  logic [6:0] div_q;
  logic       mux_q;
  logic       swap_q;
  logic       cie_q;
  logic       pie_q;
  logic       sse_q;
  logic [4:0] mode_q;
  logic [2:1] trg_s1_q;
  logic [2:1] trg_s2_q;
  logic [2:1] trg_s3_q;
  logic [2:1] trg_q;

  aqc_div_if div_bus ();

  aqc_prescaler u_prescaler (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .div_bus    (div_bus.div)
  );

  // ==========================================================
  // Decode
  wire        hit_clk  = bus_sel_i && (bus_addr_i == aqc_pkg::ADC_CLOCK_MUX_CONTROL_ADDR);
  wire        hit_q1   = bus_sel_i && (bus_addr_i == aqc_pkg::QUEUE_ONE_CONTROL_ADDR);
  wire        wr_ok    = bus_wr_i && !stop_mode_i;
  wire        wr_clk_h = hit_clk && wr_ok && bus_byte_en_i[1];
  wire        wr_clk_l = hit_clk && wr_ok && bus_byte_en_i[0];
  wire        wr_q1_h  = hit_q1 && wr_ok && bus_byte_en_i[1];
  wire [6:0]  div_rd   = (div_q == 7'h00) ? aqc_pkg::DIV_ZERO_READ : div_q;
  wire [15:0] clk_rd   = {mux_q, swap_q, 7'h00, div_rd};
  wire        sse_rd   = sse_q && test_mode_i;
  wire [15:0] q1_rd    = {cie_q, pie_q, sse_rd, mode_q, 8'h00};
  wire [15:0] rd_mux   = hit_clk ? clk_rd : (hit_q1 ? q1_rd : 16'h0000);
  // Per pin: a level counts once the second and third stages agree
  wire [2:1]  trg_new  = (trg_s2_q & trg_s3_q) | (trg_q & (trg_s2_q | trg_s3_q));
  wire        sse_set  = wr_q1_h && bus_wdata_i[aqc_pkg::Q1_SSE_BIT];
  wire        sse_wr0  = wr_q1_h && !bus_wdata_i[aqc_pkg::Q1_SSE_BIT];

  assign div_bus.divider_field = div_q;

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_q  <= aqc_pkg::ADC_CLOCK_MUX_CONTROL_RST[6:0];
      mux_q  <= aqc_pkg::ADC_CLOCK_MUX_CONTROL_RST[15];
      swap_q <= aqc_pkg::ADC_CLOCK_MUX_CONTROL_RST[14];
    end else begin
      if (wr_clk_l) begin
        div_q <= bus_wdata_i[6:0];
      end
      if (wr_clk_h) begin
        mux_q  <= bus_wdata_i[aqc_pkg::MUX_MODE_BIT];
        swap_q <= bus_wdata_i[aqc_pkg::TRIG_SWAP_BIT];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cie_q  <= 1'b0;
      pie_q  <= 1'b0;
      mode_q <= aqc_pkg::Q1_MODE_DISABLED;
    end else if (stop_mode_i) begin
      cie_q  <= 1'b0;
      pie_q  <= 1'b0;
      mode_q <= aqc_pkg::Q1_MODE_DISABLED;
    end else if (wr_q1_h) begin
      cie_q  <= bus_wdata_i[aqc_pkg::Q1_CIE_BIT];
      pie_q  <= bus_wdata_i[aqc_pkg::Q1_PIE_BIT];
      mode_q <= bus_wdata_i[aqc_pkg::Q1_MODE_LSB +: aqc_pkg::Q1_MODE_WIDTH];
    end
  end

  // Arm bit: a software set wins over a same-cycle done
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sse_q <= 1'b0;
    end else if (stop_mode_i || sse_wr0) begin
      sse_q <= 1'b0;
    end else if (sse_set) begin
      sse_q <= 1'b1;
    end else if (q1_scan_done_i) begin
      sse_q <= 1'b0;
    end
  end

  // ==========================================================
  // Trigger pin synchroniser
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trg_s1_q <= 2'h0;
      trg_s2_q <= 2'h0;
      trg_s3_q <= 2'h0;
      trg_q    <= 2'h0;
    end else begin
      trg_s1_q <= ext_trigger_pins_i;
      trg_s2_q <= trg_s1_q;
      trg_s3_q <= trg_s2_q;
      trg_q    <= trg_new;
    end
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus_rdata_o          <= 16'h0000;
      bus_ack_o            <= 1'b0;
      bus_err_o            <= 1'b0;
      sample_clock_o       <= 1'b0;
      external_mux_mode_o  <= 1'b0;
      channel_limit_o      <= aqc_pkg::CHAN_MAX_INT;
      mux_address_pins_o   <= 2'h0;
      mux_address_oe_o     <= 2'h0;
      q1_trigger_o         <= 1'b0;
      q2_trigger_o         <= 1'b0;
      q1_mode_field_o      <= aqc_pkg::Q1_MODE_DISABLED;
      q1_single_scan_arm_o <= 1'b0;
      q1_complete_irq_o    <= 1'b0;
      q1_pause_irq_o       <= 1'b0;
    end else begin
      bus_rdata_o          <= (bus_sel_i && !bus_wr_i) ? rd_mux : 16'h0000;
      bus_ack_o            <= hit_clk || hit_q1;
      bus_err_o            <= 1'b0;
      sample_clock_o       <= div_bus.sample_tick;
      external_mux_mode_o  <= mux_q;
      channel_limit_o      <= mux_q ? aqc_pkg::CHAN_MAX_EXT : aqc_pkg::CHAN_MAX_INT;
      mux_address_pins_o   <= mux_q ? mux_addr_i : 2'h0;
      mux_address_oe_o     <= {2{mux_q}};
      q1_trigger_o         <= swap_q ? trg_q[2] : trg_q[1];
      q2_trigger_o         <= swap_q ? trg_q[1] : trg_q[2];
      q1_mode_field_o      <= mode_q;
      q1_single_scan_arm_o <= sse_q;
      q1_complete_irq_o    <= cie_q && q1_last_ccw_done_i;
      q1_pause_irq_o       <= pie_q && q1_pause_ccw_done_i;
    end
  end

  // ==========================================================
  // Checks
  sequence s_stop_write;
    stop_mode_i && bus_wr_i && hit_clk;
  endsequence

  property p_stop_blocks;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      s_stop_write |=> $stable(div_q) && $stable(mux_q) && $stable(swap_q);
  endproperty
  a_stop_blocks: assert property (p_stop_blocks) else $error("Write in stop changed clock register");

  property p_stop_clears;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      stop_mode_i |=> (mode_q == 5'h00) && !cie_q && !pie_q && !sse_q;
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("Stop did not clear queue 1 register");

  property p_zero_reads_one;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (hit_clk && !bus_wr_i && div_q == 7'h00) |=> bus_rdata_o[6:0] == 7'h01;
  endproperty
  a_zero_reads_one: assert property (p_zero_reads_one) else $error("Zero divider did not read one");

  property p_mux_oe;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      mux_q |=> mux_address_oe_o == 2'h3;
  endproperty
  a_mux_oe: assert property (p_mux_oe) else $error("Mux address pins not driven");

  property p_swap;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      swap_q |=> q1_trigger_o == $past(trg_q[2]);
  endproperty
  a_swap: assert property (p_swap) else $error("Trigger routing wrong when swapped");

  property p_complete_irq;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      q1_last_ccw_done_i |=> q1_complete_irq_o == $past(cie_q);
  endproperty
  a_complete_irq: assert property (p_complete_irq) else $error("Completion request mismatch");

  property p_pause_irq;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      q1_pause_ccw_done_i |=> q1_pause_irq_o == $past(pie_q);
  endproperty
  a_pause_irq: assert property (p_pause_irq) else $error("Pause request mismatch");

  property p_sse_hidden;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (hit_q1 && !bus_wr_i && !test_mode_i) |=> !bus_rdata_o[13];
  endproperty
  a_sse_hidden: assert property (p_sse_hidden) else $error("Arm bit visible outside test");

  property p_no_err;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (hit_clk || hit_q1) |=> bus_ack_o && !bus_err_o;
  endproperty
  a_no_err: assert property (p_no_err) else $error("Access not acked cleanly");

  property p_div_two;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (div_q == 7'h00 && $stable(div_q) && sample_clock_o) |=> !sample_clock_o ##1 sample_clock_o;
  endproperty
  a_div_two: assert property (p_div_two) else $error("Zero divider not dividing by two");
endmodule // aqc_ctrl

/* File: bench/aqc_far_side.sv */
`timescale 1ns/1ps
// ==========================================================
// Far side: trigger pins, mux sequencer, queue 1 events
module aqc_far_side (
  input  wire logic       core_clk_i,
  output logic      [2:1] ext_trigger_pins_o,
  output logic      [1:0] mux_addr_o,
  output logic      [2:0] event_o
);
  initial begin
    ext_trigger_pins_o = 2'h0;
    mux_addr_o = 2'h0;
    event_o = 3'h0;
  end
  // Sequencer steps the address every cycle
  always @(negedge core_clk_i) begin
    mux_addr_o <= mux_addr_o + 2'h1;
  end
  task automatic trig(input logic [2:1] v);
    @(negedge core_clk_i);
    ext_trigger_pins_o = v;
  endtask
  // One-cycle pulse: [0] scan done, [1] last word, [2] pause word
  task automatic pulse(input logic [2:0] k);
    @(negedge core_clk_i);
    event_o = k;
    @(negedge core_clk_i);
    event_o = 3'h0;
  endtask
endmodule // aqc_far_side

/* File: bench/adc_clock_and_queue_ctrl_tb.sv */
`timescale 1ns/1ps
module adc_clock_and_queue_ctrl_tb;
  logic core_clk_i = 1'b0, reset_n_i = 1'b0, sel = 1'b0, wr = 1'b0, stop = 1'b0, tst = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [15:0] wd = 16'h0, rdata;
  logic [1:0] mpins, moe, maddr, be = 2'h3;
  logic [2:1] tpins;
  logic [2:0] ev;
  logic [4:0] lim, mode;
  logic ack, err, sclk, xmux, q1t, q2t, arm, cirq, pirq;
  int n_errors = 0, total_checks = 0;
  localparam logic [31:0] A0 = aqc_pkg::ADC_CLOCK_MUX_CONTROL_ADDR;
  localparam logic [31:0] A1 = aqc_pkg::QUEUE_ONE_CONTROL_ADDR;
  always #20 core_clk_i = ~core_clk_i;
  aqc_far_side far_u (.core_clk_i(core_clk_i), .ext_trigger_pins_o(tpins), .mux_addr_o(maddr), .event_o(ev));
  aqc_ctrl dut_u (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .bus_addr_i(addr), .bus_sel_i(sel),
    .bus_wr_i(wr), .bus_byte_en_i(be), .bus_wdata_i(wd), .bus_rdata_o(rdata), .bus_ack_o(ack),
    .bus_err_o(err), .stop_mode_i(stop), .test_mode_i(tst), .ext_trigger_pins_i(tpins), .mux_addr_i(maddr),
    .q1_scan_done_i(ev[0]), .q1_last_ccw_done_i(ev[1]), .q1_pause_ccw_done_i(ev[2]), .sample_clock_o(sclk),
    .external_mux_mode_o(xmux), .channel_limit_o(lim), .mux_address_pins_o(mpins), .mux_address_oe_o(moe),
    .q1_trigger_o(q1t), .q2_trigger_o(q2t), .q1_mode_field_o(mode), .q1_single_scan_arm_o(arm),
    .q1_complete_irq_o(cirq), .q1_pause_irq_o(pirq));
  task automatic close_out();
    if (n_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ==========================================================
  // Bus access, one strobe cycle, answer after the next edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [15:0] d, input logic eack,
                     output logic [15:0] r);
    @(negedge core_clk_i);
    sel = 1'b1;
    wr = w;
    addr = a;
    wd = d;
    @(negedge core_clk_i);
    r = rdata;
    chk({15'h0, ack}, {15'h0, eack});
    chk({15'h0, err}, 16'h0);
    sel = 1'b0;
    wd = ~d;
  endtask
  task automatic wrr(input logic [31:0] a, input logic [15:0] d);
    logic [15:0] r;
    bus(1'b1, a, d, 1'b1, r);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [15:0] e);
    logic [15:0] r;
    bus(1'b0, a, 16'h0, 1'b1, r);
    chk(r, e);
  endtask
  task automatic nxt(output int n);
    n = 0;
    do begin
      @(negedge core_clk_i);
      n++;
    end while (sclk !== 1'b1 && n < 300);
    if (n >= 300) begin
      n_errors++;
      close_out();
    end
  endtask
  task automatic per(input int e);
    int n;
    nxt(n);
    nxt(n);
    chk(16'(n), 16'(e));
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rdc(A0, 16'h0001);
    chk({7'h0, lim, moe, mpins}, 16'h0080);
    per(2);
  endtask
  task automatic t_div();
    wrr(A0, 16'h0005);
    per(6);
    wrr(A0, 16'h007f);
    per(128);
    wrr(A0, 16'h0001);
    per(2);
  endtask
  task automatic t_mux();
    wrr(A0, 16'h8003);
    // Outputs follow the register one edge later
    @(negedge core_clk_i);
    #1;
    chk({6'h0, xmux, lim, moe, mpins}, {6'h0, 1'b1, 5'h12, 2'h3, 2'(maddr - 2'h1)});
    wrr(A0, 16'h0003);
    @(negedge core_clk_i);
    #1;
    chk({6'h0, xmux, lim, moe, mpins}, {6'h0, 1'b0, 5'h08, 4'h0});
  endtask
  task automatic t_trig(input logic sw);
    wrr(A0, {1'b0, sw, 14'h0});
    far_u.trig(2'b01);
    repeat (6) @(negedge core_clk_i);
    chk({14'h0, q1t, q2t}, {14'h0, ~sw, sw});
    far_u.trig(2'b10);
    repeat (6) @(negedge core_clk_i);
    chk({14'h0, q1t, q2t}, {14'h0, sw, ~sw});
  endtask
  task automatic t_bits();
    wrr(A0, 16'hffff);
    rdc(A0, 16'hc07f);
    // Byte lanes write only their own half
    be = 2'h1;
    wrr(A0, 16'h0003);
    rdc(A0, 16'hc003);
    be = 2'h2;
    wrr(A0, 16'h0005);
    rdc(A0, 16'h0003);
    wrr(A1, 16'hffff);
    rdc(A1, 16'hdf00);
    be = 2'h1;
    wrr(A1, 16'h0000);
    rdc(A1, 16'hdf00);
    be = 2'h3;
    for (int m = 0; m < 32; m++) begin
      wrr(A1, {3'h0, 5'(m), 8'h0});
      @(negedge core_clk_i);
      chk({11'h0, mode}, 16'(m));
    end
  endtask
  task automatic t_arm_irq();
    tst = 1'b1;
    wrr(A1, 16'he100);
    rdc(A1, 16'he100);
    chk({15'h0, arm}, 16'h0001);
    far_u.pulse(3'h1);
    rdc(A1, 16'hc100);
    chk({15'h0, arm}, 16'h0000);
    far_u.pulse(3'h2);
    chk({14'h0, cirq, pirq}, 16'h2);
    far_u.pulse(3'h4);
    chk({14'h0, cirq, pirq}, 16'h1);
    wrr(A1, 16'h0000);
    far_u.pulse(3'h6);
    chk({14'h0, cirq, pirq}, 16'h0);
    tst = 1'b0;
  endtask
  task automatic t_stop();
    logic [15:0] r;
    wrr(A0, 16'h0005);
    wrr(A1, 16'hc100);
    stop = 1'b1;
    repeat (2) @(negedge core_clk_i);
    wrr(A0, 16'h8000);
    rdc(A0, 16'h0005);
    rdc(A1, 16'h0000);
    chk({11'h0, mode}, 16'h0);
    stop = 1'b0;
    bus(1'b0, 32'h00ca0010, 16'h0, 1'b0, r);
  endtask
  initial begin
    repeat (10) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    t_reset();
    t_div();
    t_mux();
    t_trig(1'b0);
    t_trig(1'b1);
    t_bits();
    t_arm_irq();
    t_stop();
    close_out();
  end
endmodule // adc_clock_and_queue_ctrl_tb
